// >>> hw/pwcr_pkg.sv
// pwcr_pkg: constants and types of the pin wake-up configuration bank
// assumes a 20 MHz system clock and a 16-bit SPI frame
package pwcr_pkg;

  // ----------------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------------
  localparam int unsigned FRAME_BITS = 16;
  localparam logic [4:0] FRAME_LEN = 5'h10;
  localparam logic [4:0] HDR_LAST_IDX = 5'h06;
  localparam int unsigned RW_BIT = 15;
  localparam logic [5:0] ADDR_CFG_LOW = 6'h04;
  localparam logic [5:0] ADDR_CFG_HIGH = 6'h05;

  // ----------------------------------------------------------------------
  // register fields and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] CFG_LOW_RST = 8'h00;
  localparam logic [7:0] CFG_HIGH_RST = 8'h00;
  localparam int unsigned SEL_A_POS = 6;
  localparam int unsigned SEL_B_POS = 4;
  localparam int unsigned SEL_C_POS = 2;
  localparam int unsigned MASK_HI_POS = 1;
  localparam int unsigned MASK_LO_POS = 0;
  localparam int unsigned NUM_PINS = 6;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned INT_LONG_US = 100;
  localparam int unsigned INT_SHORT_US = 25;
  localparam logic [10:0] INT_LONG_CNT = 11'(INT_LONG_US * CLK_MHZ);
  localparam logic [10:0] INT_SHORT_CNT = 11'(INT_SHORT_US * CLK_MHZ);

  // ----------------------------------------------------------------------
  // frame sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    PWCR_IDLE = 3'b001,
    PWCR_SHIFT = 3'b010,
    PWCR_END = 3'b100
  } pwcr_state_t;

endpackage

// >>> hw/pwcr_pin_if.sv
// pwcr_pin_if: pins, edge selections and edge events between the bank
// and its edge detector; single clock domain
`timescale 1ns/10ps
`default_nettype none
interface pwcr_pin_if;
  logic [5:0] pins;
  logic [5:0][1:0] edge_sel;
  logic [5:0] rise;
  logic [5:0] fall;
  logic [5:0] wake_hit;

  modport det (input pins, input edge_sel, output rise, output fall, output wake_hit);
  modport ctl (output pins, output edge_sel, input rise, input fall, input wake_hit);
endinterface
`default_nettype wire

// >>> hw/pwcr_pin_edge.sv
// pwcr_pin_edge: per-pin synchroniser, edge detector and wake qualifier
// assumes pins are asynchronous to i_clk
`timescale 1ns/10ps
`default_nettype none
module pwcr_pin_edge
  import pwcr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  pwcr_pin_if.det pin_if
);

  // ----------------------------------------------------------------------
  // one synchroniser and edge stage per pin
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge i_clk) begin
      if (i_srst) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
        prev_q <= 1'b0;
      end else begin
        meta_q <= pin_if.pins[g];
        sync_q <= meta_q;
        prev_q <= sync_q;
      end
    end

    // single pulse per edge of the synchronised level
    assign pin_if.rise[g] = sync_q & ~prev_q;
    assign pin_if.fall[g] = ~sync_q & prev_q;
    // bit 0 of the selection enables rising, bit 1 falling
    assign pin_if.wake_hit[g] = (pin_if.edge_sel[g][0] & pin_if.rise[g])
                              | (pin_if.edge_sel[g][1] & pin_if.fall[g]);
  end

endmodule
`default_nettype wire

// >>> hw/pwcr_top.sv
// pwcr_top: two wake-up configuration registers behind a 16-bit SPI slave
// assumes SPI inputs synchronous to i_clk, sclk idle low, data sampled
// on sclk rising and shifted out on sclk falling, msb first
`timescale 1ns/10ps
`default_nettype none
module pwcr_top
  import pwcr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_miso_oe,
  input wire logic [5:0] i_io_pin,
  input wire logic i_low_power,
  input wire logic i_int_duration,
  input wire logic i_spi_g,
  input wire logic i_can_g,
  input wire logic i_vpre_g,
  input wire logic i_vcore_g,
  input wire logic i_vothers_g,
  input wire logic i_io_other_g,
  input wire logic i_wake_clr,
  input wire logic i_io_flag_clr,
  output logic o_int_pulse,
  output logic o_wake_req,
  output logic o_wake_event_flag,
  output logic o_io_group_flag,
  output logic [7:0] o_cfg_low,
  output logic [7:0] o_cfg_high
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  pwcr_state_t state_q, state_d;
  logic sclk_q;
  logic cs_n_q;
  logic [4:0] bit_cnt_q;
  logic [15:0] mosi_sh_q;
  logic [15:0] miso_sh_q;
  logic [7:0] cfg_low_q;
  logic [7:0] cfg_high_q;
  logic [5:0] io_evt_q;
  logic wake_flag_q;
  logic wake_req_q;
  logic [10:0] int_cnt_q;
  logic int_q;

  pwcr_pin_if pin_if ();

  // ----------------------------------------------------------------------
  // spi strobes
  // ----------------------------------------------------------------------
  wire sclk_rise = i_sclk & ~sclk_q;
  wire sclk_fall = ~i_sclk & sclk_q;
  wire cs_fall = ~i_cs_n & cs_n_q;
  wire cs_rise = i_cs_n & ~cs_n_q;
  wire in_frame = (state_q == PWCR_SHIFT);

  // header is complete on the rising edge that takes bit 9
  wire hdr_done = in_frame & sclk_rise & (bit_cnt_q == HDR_LAST_IDX);
  wire [6:0] hdr_bits = {mosi_sh_q[5:0], i_mosi};
  wire hdr_low = (hdr_bits[5:0] == ADDR_CFG_LOW);
  wire hdr_high = (hdr_bits[5:0] == ADDR_CFG_HIGH);
  wire [7:0] hdr_data = hdr_low ? cfg_low_q : (hdr_high ? cfg_high_q : 8'h00);

  // completed frame decode
  wire frm_full = (bit_cnt_q == FRAME_LEN);
  wire frm_write = mosi_sh_q[RW_BIT];
  wire [5:0] frm_addr = mosi_sh_q[14:9];
  wire frm_par_ok = ^mosi_sh_q; // odd parity over all sixteen bits
  wire frm_commit = (state_q == PWCR_END) & frm_full & frm_write & frm_par_ok;
  wire wr_low = frm_commit & (frm_addr == ADDR_CFG_LOW);
  wire wr_high = frm_commit & (frm_addr == ADDR_CFG_HIGH);

  // ----------------------------------------------------------------------
  // global flag byte
  // ----------------------------------------------------------------------
  wire [7:0] flag_byte = {i_spi_g, wake_flag_q, i_can_g, 1'b0, o_io_group_flag,
                          i_vpre_g, i_vcore_g, i_vothers_g};

  // ----------------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      PWCR_IDLE: begin
        if (cs_fall) begin
          state_d = PWCR_SHIFT;
        end
      end
      PWCR_SHIFT: begin
        if (cs_rise) begin
          state_d = PWCR_END;
        end
      end
      PWCR_END: begin
        state_d = PWCR_IDLE;
      end
      default: begin
        state_d = PWCR_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_q <= PWCR_IDLE;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
    end else begin
      state_q <= state_d;
      sclk_q <= i_sclk;
      cs_n_q <= i_cs_n;
    end
  end

  // ----------------------------------------------------------------------
  // mosi shifter and bit count
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      bit_cnt_q <= 5'h00;
      mosi_sh_q <= 16'h0000;
    end else if (cs_fall) begin
      bit_cnt_q <= 5'h00;
      mosi_sh_q <= 16'h0000;
    end else if (in_frame && sclk_rise) begin
      mosi_sh_q <= {mosi_sh_q[14:0], i_mosi};
      if (bit_cnt_q <= FRAME_LEN) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // miso shifter: flags first, register byte patched in after header
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      miso_sh_q <= 16'h0000;
    end else if (cs_fall) begin
      miso_sh_q <= {flag_byte, 8'h00};
    end else if (hdr_done) begin
      miso_sh_q[13:6] <= hdr_data;
    end else if (in_frame && sclk_fall) begin
      miso_sh_q <= {miso_sh_q[14:0], 1'b0};
    end
  end

  assign o_miso = miso_sh_q[15];
  assign o_miso_oe = ~i_cs_n;

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cfg_low_q <= CFG_LOW_RST;
      cfg_high_q <= CFG_HIGH_RST;
    end else begin
      if (wr_low) begin
        cfg_low_q <= mosi_sh_q[7:0];
      end
      if (wr_high) begin
        cfg_high_q <= mosi_sh_q[7:0];
      end
    end
  end

  assign o_cfg_low = cfg_low_q;
  assign o_cfg_high = cfg_high_q;

  // ----------------------------------------------------------------------
  // field extraction
  // ----------------------------------------------------------------------
  wire [1:0] pin0_wake_edge_sel = cfg_low_q[SEL_A_POS +: 2];
  wire [1:0] pin1_wake_edge_sel = cfg_low_q[SEL_B_POS +: 2];
  wire [1:0] pin2_wake_edge_sel = cfg_low_q[SEL_C_POS +: 2];
  wire [1:0] pin3_wake_edge_sel = cfg_high_q[SEL_A_POS +: 2];
  wire [1:0] pin4_wake_edge_sel = cfg_high_q[SEL_B_POS +: 2];
  wire [1:0] pin5_wake_edge_sel = cfg_high_q[SEL_C_POS +: 2];

  wire mask_pin1 = cfg_low_q[MASK_HI_POS];
  wire mask_pin0 = cfg_low_q[MASK_LO_POS];
  wire mask_pin23 = cfg_high_q[MASK_HI_POS];
  wire mask_pin45 = cfg_high_q[MASK_LO_POS];
  wire [5:0] pin_mask = {mask_pin45, mask_pin45, mask_pin23, mask_pin23,
                         mask_pin1, mask_pin0};

  // ----------------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------------
  assign pin_if.pins = i_io_pin;
  assign pin_if.edge_sel = {pin5_wake_edge_sel, pin4_wake_edge_sel, pin3_wake_edge_sel,
                            pin2_wake_edge_sel, pin1_wake_edge_sel, pin0_wake_edge_sel};

  pwcr_pin_edge u_pin_edge (
    .i_clk (i_clk),
    .i_srst (i_srst),
    .pin_if (pin_if.det)
  );

  wire [5:0] pin_change = pin_if.rise | pin_if.fall;
  wire [5:0] io_evt_set = pin_change & ~pin_mask;
  wire wake_hit_any = i_low_power & (|pin_if.wake_hit);
  wire int_start = |io_evt_set;

  // ----------------------------------------------------------------------
  // io group flag and wake event flag; set wins over clear
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      io_evt_q <= 6'h00;
      wake_flag_q <= 1'b0;
      wake_req_q <= 1'b0;
    end else begin
      io_evt_q <= io_evt_set | (io_evt_q & {6{~i_io_flag_clr}});
      wake_flag_q <= wake_hit_any | (wake_flag_q & ~i_wake_clr);
      wake_req_q <= wake_hit_any;
    end
  end

  // masked pins never reach the group flag
  assign o_io_group_flag = i_io_other_g | (|(io_evt_q & ~pin_mask));
  assign o_wake_event_flag = wake_flag_q;
  assign o_wake_req = wake_req_q;

  // ----------------------------------------------------------------------
  // interrupt pulse timer, retriggered by each unmasked event
  // ----------------------------------------------------------------------
  wire [10:0] int_len = i_int_duration ? INT_SHORT_CNT : INT_LONG_CNT;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      int_cnt_q <= 11'h000;
      int_q <= 1'b0;
    end else if (int_start) begin
      int_cnt_q <= int_len - 11'h001;
      int_q <= 1'b1;
    end else if (int_cnt_q != 11'h000) begin
      int_cnt_q <= int_cnt_q - 11'h001;
      int_q <= 1'b1;
    end else begin
      int_q <= 1'b0;
    end
  end

  assign o_int_pulse = int_q;

endmodule
`default_nettype wire

// >>> tb/pwcr_host.sv
// pwcr_host: behavioural SPI master for the wake-up bank
// assumes xfer is called 1 ns after a rising edge of i_clk
`timescale 1ns/10ps
`default_nettype none
module pwcr_host (
  input wire logic i_clk,
  input wire logic i_miso,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_mosi
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_mosi = 1'b1;
  end
  // msb first, sclk 2 cycles high then 2 low per bit
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    o_cs_n = 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
    for (int i = 15; i >= 0; i--) begin
      o_mosi = w[i];
      r[i] = i_miso;
      o_sclk = 1'b1;
      repeat (2) @(posedge i_clk);
      #1 o_sclk = 1'b0;
      repeat (2) @(posedge i_clk);
      #1;
    end
    o_cs_n = 1'b1;
    o_mosi = ~o_mosi;
    repeat (6) @(posedge i_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// >>> tb/pwcr_top_props.sv
// pwcr_props: port-level checks of the wake-up bank
// assumes the bench never retriggers an interrupt pulse
`timescale 1ns/10ps
`default_nettype none
module pwcr_props (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_cs_n,
  input wire logic i_low_power,
  input wire logic i_int_duration,
  input wire logic i_io_other_g,
  input wire logic o_miso_oe,
  input wire logic o_int_pulse,
  input wire logic o_wake_req,
  input wire logic o_wake_event_flag,
  input wire logic o_io_group_flag,
  input wire logic [7:0] o_cfg_low,
  input wire logic [7:0] o_cfg_high
);
  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  logic all_mask;
  assign cnt_d = o_int_pulse ? cnt_q + 12'h001 : 12'h000;
  assign all_mask = &{o_cfg_low[1:0], o_cfg_high[1:0]};
  always_ff @(posedge i_clk) begin
    cnt_q <= i_srst ? 12'h000 : cnt_d;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  miso_enable_a: assert property (o_miso_oe == !i_cs_n)
    else $error("miso enable wrong");
  cfg_commit_a: assert property (($changed(o_cfg_low) || $changed(o_cfg_high))
    |-> $past(i_cs_n) && $past(i_cs_n, 2)) else $error("cfg changed in frame");
  int_width_a: assert property ($fell(o_int_pulse)
    |-> cnt_q == (i_int_duration ? 12'h1F4 : 12'h7D0)) else $error("int width");
  wake_single_a: assert property (o_wake_req |=> !o_wake_req)
    else $error("wake pulse too long");
  wake_lowpow_a: assert property (o_wake_req |-> $past(i_low_power))
    else $error("wake outside low power");
  wake_flag_a: assert property ($rose(o_wake_event_flag) |-> o_wake_req)
    else $error("wake flag without wake");
  wake_off_a: assert property (o_wake_req
    |-> (o_cfg_low[7:2] != 6'h00) || (o_cfg_high[7:2] != 6'h00)) else $error("wake off");
  io_mask_a: assert property ($rose(o_io_group_flag) && !i_io_other_g
    |-> !all_mask) else $error("masked pin in io group");
  int_mask_a: assert property ($rose(o_int_pulse) |-> !all_mask)
    else $error("masked pin raised int");
endmodule
bind pwcr_top pwcr_props i_props (.i_clk(i_clk), .i_srst(i_srst), .i_cs_n(i_cs_n),
  .i_low_power(i_low_power), .i_int_duration(i_int_duration), .i_io_other_g(i_io_other_g),
  .o_miso_oe(o_miso_oe), .o_int_pulse(o_int_pulse), .o_wake_req(o_wake_req),
  .o_wake_event_flag(o_wake_event_flag), .o_io_group_flag(o_io_group_flag),
  .o_cfg_low(o_cfg_low), .o_cfg_high(o_cfg_high));
`default_nettype wire

// >>> tb/pwcr_top_bench.sv
// pwcr_top_bench: self-checking bench of the wake-up bank
// assumes pwcr_host as SPI master and the bound checker
`timescale 1ns/10ps
`default_nettype none
module pwcr_top_bench;
  import pwcr_pkg::*;
  logic clk, srst, lp, dur, spi_g, can_g, vpre_g, vcore_g, vothers_g, io_oth, wclr, fclr;
  logic [5:0] pin;
  wire logic cs_n, sclk, mosi, miso, miso_oe, int_p, wreq, wflag, iog;
  wire logic [7:0] cfg_lo, cfg_hi;
  int n_fail = 0;
  int checked = 0;
  int n_wake = 0;
  pwcr_top i_dut (.i_clk(clk), .i_srst(srst), .i_cs_n(cs_n), .i_sclk(sclk), .i_mosi(mosi),
    .o_miso(miso), .o_miso_oe(miso_oe), .i_io_pin(pin), .i_low_power(lp),
    .i_int_duration(dur), .i_spi_g(spi_g), .i_can_g(can_g), .i_vpre_g(vpre_g),
    .i_vcore_g(vcore_g), .i_vothers_g(vothers_g), .i_io_other_g(io_oth), .i_wake_clr(wclr),
    .i_io_flag_clr(fclr), .o_int_pulse(int_p), .o_wake_req(wreq), .o_wake_event_flag(wflag),
    .o_io_group_flag(iog), .o_cfg_low(cfg_lo), .o_cfg_high(cfg_hi));
  pwcr_host i_host (.i_clk(clk), .i_miso(miso), .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // count on the falling edge, where the registered pulse has settled
  always @(negedge clk) begin
    if (wreq === 1'b1) n_wake++;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  function automatic logic [15:0] mk(input logic [5:0] a, input logic [7:0] d);
    logic [15:0] w;
    w = {1'b1, a, 1'b0, d};
    w[8] = ~^w;
    return w;
  endfunction
  function automatic logic [7:0] fl(input logic wf, input logic io);
    return {spi_g, wf, can_g, 1'b0, io, vpre_g, vcore_g, vothers_g};
  endfunction
  task automatic acc(input logic [15:0] w, input logic [15:0] exp);
    logic [15:0] r;
    i_host.xfer(w, r);
    cmp("miso word", exp, r);
  endtask
  task automatic pw(input logic [15:0] exp);
    int w;
    w = 0;
    for (int k = 0; k < 10 && int_p !== 1'b1; k++) tick(1);
    while (int_p === 1'b1 && w < 3000) begin
      tick(1);
      w++;
    end
    cmp("int width", exp, 16'(w));
  endtask
  task automatic t_regs;
    acc({1'b0, ADDR_CFG_LOW, 9'h000}, {fl(1'b0, 1'b0), 8'h00});
    acc({1'b0, ADDR_CFG_HIGH, 9'h000}, {fl(1'b0, 1'b0), 8'h00});
    acc(mk(ADDR_CFG_LOW, 8'h6F), {fl(1'b0, 1'b0), 8'h00});
    acc(mk(ADDR_CFG_HIGH, 8'hDB), {fl(1'b0, 1'b0), 8'h00});
    acc(mk(ADDR_CFG_LOW, 8'h10) ^ 16'h0100, {fl(1'b0, 1'b0), 8'h6F});
    // unknown address: data byte reads zero and nothing is written
    acc(mk(6'h06, 8'hFF), {fl(1'b0, 1'b0), 8'h00});
    acc({1'b0, ADDR_CFG_LOW, 9'h000}, {fl(1'b0, 1'b0), 8'h6F});
    acc({1'b0, ADDR_CFG_HIGH, 9'h000}, {fl(1'b0, 1'b0), 8'hDB});
    cmp("cfg ports", 16'hDB6F, {cfg_hi, cfg_lo});
  endtask
  task automatic t_wake;
    logic [5:0] rise_m;
    logic [5:0] fall_m;
    int b;
    rise_m = 6'h1D;
    fall_m = 6'h2E;
    lp = 1'b1;
    for (int p = 0; p < 6; p++) begin
      b = n_wake;
      pin[p] = 1'b1;
      tick(8);
      cmp("wake on rise", 16'(rise_m[p]), 16'(n_wake - b));
      b = n_wake;
      pin[p] = 1'b0;
      tick(8);
      cmp("wake on fall", 16'(fall_m[p]), 16'(n_wake - b));
    end
    cmp("io group", 16'h0000, 16'(iog));
    acc(mk(ADDR_CFG_LOW, 8'h03), {fl(1'b1, 1'b0), 8'h6F});
    b = n_wake;
    pin[0] = 1'b1;
    tick(8);
    pin[0] = 1'b0;
    tick(8);
    cmp("wake code off", 16'h0000, 16'(n_wake - b));
    wclr = 1'b1;
    tick(1);
    wclr = 1'b0;
    lp = 1'b0;
    tick(1);
    cmp("wake flag", 16'h0000, 16'(wflag));
  endtask
  task automatic t_int;
    acc(mk(ADDR_CFG_LOW, 8'h01), {fl(1'b0, 1'b0), 8'h03});
    pin[0] = 1'b1;
    tick(10);
    cmp("masked int", 16'h0000, 16'(int_p));
    pin[1] = 1'b1;
    pw(16'h07D0);
    cmp("io group", 16'h0001, 16'(iog));
    acc(mk(ADDR_CFG_LOW, 8'h03), {fl(1'b0, 1'b1), 8'h01});
    pin[1] = 1'b0;
    tick(10);
    cmp("masked int", 16'h0000, 16'(int_p));
    fclr = 1'b1;
    tick(1);
    fclr = 1'b0;
    dur = 1'b1;
    acc(mk(ADDR_CFG_HIGH, 8'h00), {fl(1'b0, 1'b0), 8'hDB});
    for (int p = 2; p < 6; p++) begin
      pin[p] = 1'b1;
      pw(16'h01F4);
    end
    {spi_g, can_g, vpre_g, vcore_g, vothers_g, io_oth} = 6'h15;
    acc({1'b0, ADDR_CFG_HIGH, 9'h000}, {fl(1'b0, 1'b1), 8'h00});
  endtask
  task automatic wrap_up;
    if (n_fail == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
  initial begin
    srst = 1'b1;
    {lp, dur, wclr, fclr, io_oth} = 5'h00;
    {spi_g, can_g, vpre_g, vcore_g, vothers_g} = 5'h15;
    pin = 6'h00;
    repeat (8) @(posedge clk);
    #1 srst = 1'b0;
    t_regs();
    t_wake();
    t_int();
    wrap_up();
  end
endmodule
`default_nettype wire
